// File: pkg/bexec_cfg.svh
// Purpose: offsets, field positions, encodings and counts of the exec unit
// Assumes: 32-bit APB data, one aligned word per register
// Notes: included by bare name from the design files
`ifndef BEXEC_CFG_SVH
`define BEXEC_CFG_SVH

`define APB_AW 8
`define ADR_OPCODE 8'h00
`define ADR_SRC_A 8'h04
`define ADR_SRC_B 8'h08
`define ADR_SRC_C 8'h0C
`define ADR_SRC_D 8'h10
`define ADR_PC 8'h14
`define ADR_CCR 8'h18
`define ADR_CMD 8'h1C
`define ADR_STATUS 8'h20
`define ADR_RES0 8'h24
`define ADR_RES1 8'h28
`define ADR_NPC 8'h2C

`define CCR_C 0
`define CCR_V 1
`define CCR_Z 2
`define CCR_N 3
`define CCR_X 4

`define SB_BUSY 0
`define SB_DONE 1
`define SB_ILLEGAL 2
`define SB_TRAP 3
`define SB_OVF 4
`define SB_BRANCH 5
`define SB_WR0 6
`define SB_WR1 7

`define RST_ALL '0

`define OPC_BOUNDS_HI 5'h00
`define OPC_BOUNDS_LO 3'h3
`define OPC_LOOP_HI 4'h5
`define OPC_LOOP_LO 5'h19
`define OPC_DIVW_HI 4'h8
`define OPC_DIVW_LO 2'h3
`define OPC_DIVL 10'h131

`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2

`define EA_AREG 3'h1
`define EA_AIND 3'h2
`define EA_DISP 3'h5
`define EA_INDEX 3'h6
`define EA_EXT 3'h7
`define EAR_PCIDX 3'h3
`define EAR_IMM 3'h4

`define PC_OPCODE_ADV 32'h0000_0002
`define PC_LOOP_LEN 32'h0000_0004

`define QMAX_W_POS 64'h0000_0000_0000_7FFF
`define QMAX_W_NEG 64'h0000_0000_0000_8000
`define QMAX_W_U 64'h0000_0000_0000_FFFF
`define QMAX_L_POS 64'h0000_0000_7FFF_FFFF
`define QMAX_L_NEG 64'h0000_0000_8000_0000
`define QMAX_L_U 64'h0000_0000_FFFF_FFFF

`define DIV_STEPS 7'h40

`endif

// File: pkg/bexec_pkg.sv
// Purpose: types shared by the exec unit and its divider
// Assumes: nothing beyond SystemVerilog packed types
// Notes: numbers live in bexec_cfg.svh
package bexec_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DIV = 2'b01
    } exec_state_t;

    typedef enum logic [3:0] {
        CC_T = 4'b0000, CC_F = 4'b0001, CC_HI = 4'b0010, CC_LS = 4'b0011,
        CC_CC = 4'b0100, CC_CS = 4'b0101, CC_NE = 4'b0110, CC_EQ = 4'b0111,
        CC_VC = 4'b1000, CC_VS = 4'b1001, CC_PL = 4'b1010, CC_MI = 4'b1011,
        CC_GE = 4'b1100, CC_LT = 4'b1101, CC_GT = 4'b1110, CC_LE = 4'b1111
    } loop_condition_t;

    typedef struct packed {
        logic start;
        logic [63:0] dividend;
        logic [31:0] divisor;
    } div_req_t;

    typedef struct packed {
        logic done;
        logic [63:0] quot;
        logic [31:0] rem;
    } div_rsp_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic [6:0] cnt;
        logic [63:0] dvd;
        logic [31:0] rem;
        logic [31:0] dvs;
    } div_state_t;

    typedef struct packed {
        exec_state_t st;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [31:0] opw;
        logic [31:0] src_a;
        logic [31:0] src_b;
        logic [31:0] src_c;
        logic [31:0] src_d;
        logic [31:0] pc;
        logic [31:0] res0;
        logic [31:0] res1;
        logic [31:0] npc;
        logic [4:0] ccr;
        logic [7:0] status;
        logic div_start;
        logic [63:0] div_a;
        logic [31:0] div_b;
        logic d_sgn;
        logic d_word;
        logic d_negq;
        logic d_negr;
        logic d_rem_wr;
    } exec_regs_t;

endpackage

// File: src/div_unit.sv
// Purpose: unsigned restoring divider, 64-bit dividend by 32-bit divisor
// Assumes: divisor nonzero, start is a one-cycle pulse
// Notes: one quotient bit per clock, done pulses after the last step
`timescale 1ns/1ns
`include "bexec_cfg.svh"
module div_unit
    import bexec_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire div_req_t req,
    output div_rsp_t rsp
);

    div_state_t r;
    div_state_t n;
    logic [32:0] trial;
    logic [32:0] diff;
    logic fits;

    assign trial = {r.rem, r.dvd[63]};
    assign diff = trial - {1'b0, r.dvs};
    assign fits = trial >= {1'b0, r.dvs};

    always_comb begin
        n = r;
        n.done = 1'b0;
        if (req.start) begin
            n.busy = 1'b1;
            n.cnt = `DIV_STEPS;
            n.dvd = req.dividend;
            n.rem = 32'h0000_0000;
            n.dvs = req.divisor;
        end else if (r.busy) begin
            // dividend register shifts out its top bit and collects quotient
            n.rem = fits ? diff[31:0] : trial[31:0];
            n.dvd = {r.dvd[62:0], fits};
            n.cnt = r.cnt - 7'h01;
            if (r.cnt == 7'h01) begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            r <= `RST_ALL;
        end else begin
            r <= n;
        end
    end

    assign rsp = '{done: r.done, quot: r.dvd, rem: r.rem};

endmodule

// File: src/bounds_loop_divide_exec.sv
// Purpose: bounds compare, loop decrement-branch and divide execution
// Assumes: software loads operands and opcode over APB, then writes CMD
// Notes: bounds pair is fetched by software into SRC_B/SRC_C, the divisor into SRC_B
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ns
`include "bexec_cfg.svh"
////////////////////////////////////////////////////////////////////////////
module bounds_loop_divide_exec
    import bexec_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [`APB_AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic DIV_TRAP
);

    exec_regs_t r;
    exec_regs_t n;
    div_req_t dreq;
    div_rsp_t drsp;
    logic [31:0] wmask;
    logic acc;
    logic commit;
    logic go;
    logic [15:0] op;
    logic [15:0] ext;
    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
    logic is_bounds;
    logic is_loop;
    logic is_divw;
    logic is_divl;
    logic ctrl_ok;
    logic data_ok;
    logic cond_true;
    logic [31:0] rd_val;
    logic rd_hit;

    ////////////////////////////////////////////////////////////////////////
    // apb byte strobes and handshake
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_strb
            assign wmask[8*gi +: 8] = {8{PSTRB[gi]}};
        end
    endgenerate

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] d, input logic [31:0] m);
        return (old & ~m) | (d & m);
    endfunction

    assign acc = PSEL && PENABLE;
    assign commit = acc && r.pready;
    assign go = commit && PWRITE && (PADDR == `ADR_CMD) && PSTRB[0] &&
        PWDATA[0] && (r.st == ST_IDLE);

    always_comb begin
        rd_hit = 1'b1;
        case (PADDR)
            `ADR_OPCODE: rd_val = r.opw;
            `ADR_SRC_A: rd_val = r.src_a;
            `ADR_SRC_B: rd_val = r.src_b;
            `ADR_SRC_C: rd_val = r.src_c;
            `ADR_SRC_D: rd_val = r.src_d;
            `ADR_PC: rd_val = r.pc;
            `ADR_CCR: rd_val = {27'h0000000, r.ccr};
            `ADR_CMD: rd_val = 32'h0000_0000;
            `ADR_STATUS: rd_val = {24'h000000, r.status};
            `ADR_RES0: rd_val = r.res0;
            `ADR_RES1: rd_val = r.res1;
            `ADR_NPC: rd_val = r.npc;
            default: begin
                rd_val = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction decode
    assign op = r.opw[15:0];
    assign ext = r.opw[31:16];
    assign ea_mode = op[5:3];
    assign ea_reg = op[2:0];
    assign is_bounds = (op[15:11] == `OPC_BOUNDS_HI) &&
        (op[8:6] == `OPC_BOUNDS_LO) && (ext[11:0] == 12'h000);
    assign is_loop = (op[15:12] == `OPC_LOOP_HI) &&
        (op[7:3] == `OPC_LOOP_LO);
    assign is_divw = (op[15:12] == `OPC_DIVW_HI) &&
        (op[7:6] == `OPC_DIVW_LO);
    assign is_divl = (op[15:6] == `OPC_DIVL) && (ext[15] == 1'b0) &&
        (ext[9:3] == 7'h00);

    always_comb begin
        case (ea_mode)
            `EA_AIND, `EA_DISP, `EA_INDEX: ctrl_ok = 1'b1;
            `EA_EXT: ctrl_ok = (ea_reg <= `EAR_PCIDX);
            default: ctrl_ok = 1'b0;
        endcase
        data_ok = (ea_mode != `EA_AREG) &&
            ((ea_mode != `EA_EXT) || (ea_reg <= `EAR_IMM));
    end

    ////////////////////////////////////////////////////////////////////////
    // loop condition
    always_comb begin
        case (loop_condition_t'(op[11:8]))
            CC_T: cond_true = 1'b1;
            CC_F: cond_true = 1'b0;
            CC_HI: cond_true = !r.ccr[`CCR_C] && !r.ccr[`CCR_Z];
            CC_LS: cond_true = r.ccr[`CCR_C] || r.ccr[`CCR_Z];
            CC_CC: cond_true = !r.ccr[`CCR_C];
            CC_CS: cond_true = r.ccr[`CCR_C];
            CC_NE: cond_true = !r.ccr[`CCR_Z];
            CC_EQ: cond_true = r.ccr[`CCR_Z];
            CC_VC: cond_true = !r.ccr[`CCR_V];
            CC_VS: cond_true = r.ccr[`CCR_V];
            CC_PL: cond_true = !r.ccr[`CCR_N];
            CC_MI: cond_true = r.ccr[`CCR_N];
            CC_GE: cond_true = r.ccr[`CCR_N] == r.ccr[`CCR_V];
            CC_LT: cond_true = r.ccr[`CCR_N] != r.ccr[`CCR_V];
            CC_GT: cond_true = !r.ccr[`CCR_Z] &&
                (r.ccr[`CCR_N] == r.ccr[`CCR_V]);
            CC_LE: cond_true = r.ccr[`CCR_Z] ||
                (r.ccr[`CCR_N] != r.ccr[`CCR_V]);
            default: cond_true = 1'b0;
        endcase
    end

    logic [15:0] cnt;
    logic [31:0] disp32;
    assign cnt = r.src_a[15:0] - 16'h0001;
    assign disp32 = {{16{ext[15]}}, ext};

    ////////////////////////////////////////////////////////////////////////
    // bounds compare: src_b lower, src_c upper
    logic [31:0] bv;
    logic [31:0] blo;
    logic [31:0] bhi;
    logic b_out;
    logic b_z;
    always_comb begin
        bv = r.src_a;
        blo = r.src_b;
        bhi = r.src_c;
        if (ext[15]) begin
            case (op[10:9])
                `SZ_BYTE: begin
                    blo = {{24{r.src_b[7]}}, r.src_b[7:0]};
                    bhi = {{24{r.src_c[7]}}, r.src_c[7:0]};
                end
                `SZ_WORD: begin
                    blo = {{16{r.src_b[15]}}, r.src_b[15:0]};
                    bhi = {{16{r.src_c[15]}}, r.src_c[15:0]};
                end
                default: begin
                    blo = r.src_b;
                    bhi = r.src_c;
                end
            endcase
        end else begin
            case (op[10:9])
                `SZ_BYTE: begin
                    bv = {24'h000000, r.src_a[7:0]};
                    blo = {24'h000000, r.src_b[7:0]};
                    bhi = {24'h000000, r.src_c[7:0]};
                end
                `SZ_WORD: begin
                    bv = {16'h0000, r.src_a[15:0]};
                    blo = {16'h0000, r.src_b[15:0]};
                    bhi = {16'h0000, r.src_c[15:0]};
                end
                default: begin
                    bv = r.src_a;
                end
            endcase
        end
        b_z = (bv == blo) || (bv == bhi);
        // a lower bound above the upper one is a range that wraps
        b_out = (blo <= bhi) ? ((bv < blo) || (bv > bhi)) :
            ((bv < blo) && (bv > bhi));
    end

    ////////////////////////////////////////////////////////////////////////
    // divide operand preparation and result
    logic dsgn;
    logic [63:0] dvd;
    logic [31:0] dvs;
    logic ndvd;
    logic ndvs;
    always_comb begin
        dsgn = is_divw ? op[8] : ext[11];
        if (is_divw) begin
            dvd = {{32{dsgn & r.src_a[31]}}, r.src_a};
            dvs = {{16{dsgn & r.src_b[15]}}, r.src_b[15:0]};
        end else begin
            dvd = ext[10] ? {r.src_d, r.src_a} :
                {{32{dsgn & r.src_a[31]}}, r.src_a};
            dvs = r.src_b;
        end
        ndvd = dsgn & dvd[63];
        ndvs = dsgn & dvs[31];
    end

    logic [63:0] sq;
    logic [31:0] sr;
    logic ovf;
    always_comb begin
        sq = r.d_negq ? (64'h0 - drsp.quot) : drsp.quot;
        sr = r.d_negr ? (32'h0000_0000 - drsp.rem) : drsp.rem;
        if (r.d_word) begin
            ovf = r.d_sgn ? (drsp.quot > (r.d_negq ? `QMAX_W_NEG :
                `QMAX_W_POS)) : (drsp.quot > `QMAX_W_U);
        end else begin
            ovf = r.d_sgn ? (drsp.quot > (r.d_negq ? `QMAX_L_NEG :
                `QMAX_L_POS)) : (drsp.quot > `QMAX_L_U);
        end
    end

    assign dreq = '{start: r.div_start, dividend: r.div_a,
        divisor: r.div_b};

    div_unit u_div (
        .clk(CLK),
        .rstn(RSTN),
        .req(dreq),
        .rsp(drsp)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        n = r;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        n.div_start = 1'b0;
        if (acc && !r.pready) begin
            n.pready = 1'b1;
            n.prdata = rd_val;
            n.pslverr = !rd_hit;
        end
        if (commit && PWRITE) begin
            case (PADDR)
                `ADR_OPCODE: n.opw = merge(r.opw, PWDATA, wmask);
                `ADR_SRC_A: n.src_a = merge(r.src_a, PWDATA, wmask);
                `ADR_SRC_B: n.src_b = merge(r.src_b, PWDATA, wmask);
                `ADR_SRC_C: n.src_c = merge(r.src_c, PWDATA, wmask);
                `ADR_SRC_D: n.src_d = merge(r.src_d, PWDATA, wmask);
                `ADR_PC: n.pc = merge(r.pc, PWDATA, wmask);
                `ADR_CCR: begin
                    n.ccr = PSTRB[0] ? PWDATA[4:0] : r.ccr;
                end
                default: begin
                end
            endcase
        end
        if (go) begin
            n.status = 8'h00;
            n.status[`SB_DONE] = 1'b1;
            if (is_bounds && ctrl_ok && (op[10:9] != 2'h3)) begin
                n.ccr[`CCR_Z] = b_z;
                n.ccr[`CCR_C] = b_out;
            end else if (is_loop) begin
                if (cond_true) begin
                    n.npc = r.pc + `PC_LOOP_LEN;
                end else begin
                    n.res0 = {r.src_a[31:16], cnt};
                    n.status[`SB_WR0] = 1'b1;
                    if (cnt == 16'hFFFF) begin
                        n.npc = r.pc + `PC_LOOP_LEN;
                    end else begin
                        n.npc = r.pc + `PC_OPCODE_ADV + disp32;
                        n.status[`SB_BRANCH] = 1'b1;
                    end
                end
            end else if ((is_divw || is_divl) && data_ok) begin
                if (dvs == 32'h0000_0000) begin
                    n.status[`SB_TRAP] = 1'b1;
                    n.ccr[`CCR_C] = 1'b0;
                end else begin
                    n.st = ST_DIV;
                    n.status[`SB_DONE] = 1'b0;
                    n.status[`SB_BUSY] = 1'b1;
                    n.div_start = 1'b1;
                    n.div_a = ndvd ? (64'h0 - dvd) : dvd;
                    n.div_b = ndvs ? (32'h0000_0000 - dvs) : dvs;
                    n.d_sgn = dsgn;
                    n.d_word = is_divw;
                    n.d_negq = ndvd ^ ndvs;
                    n.d_negr = ndvd;
                    n.d_rem_wr = ext[14:12] != ext[2:0];
                end
            end else begin
                n.status[`SB_ILLEGAL] = 1'b1;
            end
        end
        if ((r.st == ST_DIV) && drsp.done) begin
            n.st = ST_IDLE;
            n.status[`SB_BUSY] = 1'b0;
            n.status[`SB_DONE] = 1'b1;
            n.ccr[`CCR_C] = 1'b0;
            if (ovf) begin
                n.ccr[`CCR_V] = 1'b1;
                n.status[`SB_OVF] = 1'b1;
            end else begin
                n.ccr[`CCR_V] = 1'b0;
                n.status[`SB_WR0] = 1'b1;
                if (r.d_word) begin
                    n.res0 = {sr[15:0], sq[15:0]};
                    n.ccr[`CCR_N] = sq[15];
                    n.ccr[`CCR_Z] = sq[15:0] == 16'h0000;
                end else begin
                    n.res0 = sq[31:0];
                    n.res1 = sr;
                    n.status[`SB_WR1] = r.d_rem_wr;
                    n.ccr[`CCR_N] = sq[31];
                    n.ccr[`CCR_Z] = sq[31:0] == 32'h0000_0000;
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            r <= `RST_ALL;
        end else begin
            r <= n;
        end
    end

    assign PRDATA = r.prdata;
    assign PREADY = r.pready;
    assign PSLVERR = r.pslverr;
    assign DIV_TRAP = r.status[`SB_TRAP];

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    logic b_long_dr;
    logic div_go;
    assign b_long_dr = is_bounds && ctrl_ok && (op[10:9] == `SZ_LONG) &&
        !ext[15];
    assign div_go = (is_divw || is_divl) && data_ok;

    bounds_zero_a: assert property (
        go && b_long_dr |=> r.ccr[`CCR_Z] == (($past(r.src_a) ==
        $past(r.src_b)) || ($past(r.src_a) == $past(r.src_c))))
        else $error("bounds zero flag wrong");
    bounds_carry_a: assert property (
        go && b_long_dr && (r.src_b <= r.src_c) |=> $stable(r.ccr[`CCR_X])
        && r.ccr[`CCR_C] == (($past(r.src_a) < $past(r.src_b)) ||
        ($past(r.src_a) > $past(r.src_c))))
        else $error("bounds carry flag wrong");
    loop_flags_a: assert property (
        go && is_loop |=> $stable(r.ccr))
        else $error("loop changed flags");
    loop_count_a: assert property (
        go && is_loop && !cond_true |=> r.res0[31:16] ==
        $past(r.src_a[31:16]) && r.res0[15:0] == $past(cnt))
        else $error("loop counter wrong");
    loop_target_a: assert property (
        go && is_loop && !cond_true && (cnt != 16'hFFFF) |=>
        r.npc == $past(r.pc) + `PC_OPCODE_ADV + $past(disp32))
        else $error("loop branch target wrong");
    div_trap_a: assert property (
        go && div_go && (dvs == 32'h0000_0000) |=> DIV_TRAP &&
        r.st == ST_IDLE)
        else $error("zero divisor did not trap");
    div_latency_a: assert property (
        go && div_go && (dvs != 32'h0000_0000) |-> ##66
        !r.status[`SB_DONE] ##1 r.status[`SB_DONE])
        else $error("divide finished at wrong cycle");
    div_ovf_keep_a: assert property (
        r.st == ST_DIV && drsp.done && ovf |=> r.ccr[`CCR_V] &&
        !r.status[`SB_WR0] && $stable(r.res0) && $stable(r.res1))
        else $error("overflow touched destination");
    rem_sign_a: assert property (
        r.st == ST_DIV && drsp.done && !ovf && r.d_sgn && !r.d_word &&
        (drsp.rem != 32'h0000_0000) |=> r.res1[31] == $past(r.d_negr))
        else $error("remainder sign wrong");

endmodule

// File: verif/test_bounds_loop_divide_exec.sv
// Purpose: self-checking bench for the bounds, loop and divide unit
// Assumes: APB register map and command timing as handed over
// Notes: random operands from a fixed xorshift seed
`timescale 1ns/1ns
`include "bexec_cfg.svh"
module test_bounds_loop_divide_exec;
    import bexec_pkg::*;
    logic CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, r, a, b, c, x, m, e;
    logic [3:0] PSTRB = 4'hF;
    logic PREADY, PSLVERR, DIV_TRAP, ok;
    logic [31:0] seed = 32'hB82A;
    int n_mismatch = 0, comparisons = 0, cyc = 0;
    longint q, rm, dv, t;
    bounds_loop_divide_exec i_dut (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .DIV_TRAP(DIV_TRAP));
    initial forever #50 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            results();
        end
    end
////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic cond(input logic [3:0] k, input logic [4:0] f);
        logic [15:0] t;
        t = {f[2] | (f[3] ^ f[1]), ~f[2] & ~(f[3] ^ f[1]), f[3] ^ f[1],
            ~(f[3] ^ f[1]), f[3], ~f[3], f[1], ~f[1], f[2], ~f[2], f[0],
            ~f[0], f[0] | f[2], ~f[0] & ~f[2], 1'b0, 1'b1};
        return t[k];
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad,
        input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= ad;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        r = PRDATA;
        e = {31'h0, PSLVERR};
        PSEL <= 0;
        PENABLE <= 0;
    endtask
    task automatic go();
        apb(1, `ADR_CMD, 32'h1);
        for (int k = 0; k < 100; k++) begin
            apb(0, `ADR_STATUS, 0);
            if (r[`SB_DONE] === 1'b1) break;
        end
        chk(r[`SB_DONE], 1);
    endtask
    task automatic results();
        if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge CLK);
        RSTN <= 1;
        apb(0, 8'h30, 0);
        chk(e, 1);
        for (int i = 0; i < 9; i++) begin
            m = i % 3 == 0 ? 32'hFF : i % 3 == 1 ? 32'hFFFF : 32'hFFFFFFFF;
            b = rnd() & m;
            c = rnd() & m;
            if (b > c) {b, c} = {c, b};
            a = rnd();
            if (i < 2) a = (a & ~m) | (i == 0 ? b : c);
            x = rnd() & 32'h1F;
            apb(1, `ADR_OPCODE, {16'h0, 5'h00, 2'(i % 3), 3'h3, 6'h10});
            apb(1, `ADR_SRC_A, a);
            apb(1, `ADR_SRC_B, b);
            apb(1, `ADR_SRC_C, c);
            apb(1, `ADR_CCR, x);
            go();
            apb(0, `ADR_CCR, 0);
            chk(r & 32'h15, (x & 32'h10) | {((a & m) == b || (a & m) == c),
                2'b00} | {31'h0, ((a & m) < b || (a & m) > c)});
        end
        apb(1, `ADR_OPCODE, {16'h0, 5'h00, 2'h2, 3'h3, 6'h00});
        go();
        chk(r[`SB_ILLEGAL], 1);
        for (int i = 0; i < 32; i++) begin
            x = rnd() & 32'h1F;
            a = i[0] ? rnd() & 32'hFFFF0000 : rnd();
            b = rnd() & 32'hFFFFFFFE;
            c = rnd() & 32'hFFFF;
            apb(1, `ADR_OPCODE, {c[15:0], 4'h5, 4'(i), 5'h19, 3'h0});
            apb(1, `ADR_SRC_A, a);
            apb(1, `ADR_PC, b);
            apb(1, `ADR_CCR, x);
            go();
            ok = cond(4'(i), x[4:0]);
            m = ok || a[15:0] == 16'h0 ? b + 4 : b + 2 + {{16{c[15]}}, c[15:0]};
            apb(0, `ADR_NPC, 0);
            chk(r, m);
            apb(0, `ADR_CCR, 0);
            chk(r, x);
            apb(0, `ADR_RES0, 0);
            if (!ok) chk(r, {a[31:16], a[15:0] - 16'h1});
        end
        for (int i = 0; i < 12; i++) begin
            a = $signed(rnd()) >>> (4 * (i % 4));
            b = (rnd() & 32'hFFFF) | 32'h1;
            apb(1, `ADR_OPCODE, {16'h0, 4'h8, 3'h0, i[0] ? 3'h7 : 3'h3, 6'h01});
            apb(1, `ADR_SRC_A, a);
            apb(1, `ADR_SRC_B, b);
            apb(1, `ADR_CCR, 32'h1F);
            apb(0, `ADR_RES0, 0);
            x = r;
            go();
            if (i[0]) begin
                q = longint'($signed(a)) / longint'($signed(b[15:0]));
                rm = longint'($signed(a)) % longint'($signed(b[15:0]));
                ok = q > 32767 || q < -32768;
            end else begin
                q = longint'(a) / longint'(b[15:0]);
                rm = longint'(a) % longint'(b[15:0]);
                ok = q > 65535;
            end
            apb(0, `ADR_CCR, 0);
            if (ok) chk(r & 32'h13, 32'h12);
            else chk(r, {27'h1, q[15], q[15:0] == 0, 2'b00});
            apb(0, `ADR_RES0, 0);
            chk(r, ok ? x : {rm[15:0], q[15:0]});
        end
        for (int i = 0; i < 8; i++) begin
            a = rnd();
            b = rnd() | 32'h10;
            c = rnd() & 32'h7;
            apb(1, `ADR_OPCODE, {1'b0, 3'h1, i[0], i[1], 7'h00,
                i[2] ? 3'h1 : 3'h2, 10'h131, 6'h01});
            apb(1, `ADR_SRC_A, a);
            apb(1, `ADR_SRC_B, b);
            apb(1, `ADR_SRC_D, c);
            apb(1, `ADR_CCR, 32'h1F);
            go();
            if (i[1]) t = longint'({c, a});
            else if (i[0]) t = longint'($signed(a));
            else t = longint'(a);
            dv = i[0] ? longint'($signed(b)) : longint'(b);
            q = t / dv;
            rm = t % dv;
            if (i[0]) ok = q > 64'sh7FFF_FFFF || q < -64'sh8000_0000;
            else ok = q > 64'shFFFF_FFFF;
            chk(r[7:4], ok ? 4'h1 : {~i[2], 3'h4});
            apb(0, `ADR_CCR, 0);
            if (ok) chk(r & 32'h13, 32'h12);
            else chk(r, {27'h1, q[31], q[31:0] == 0, 2'b00});
            apb(0, `ADR_RES0, 0);
            if (!ok) chk(r, q[31:0]);
            apb(0, `ADR_RES1, 0);
            if (!ok) chk(r, rm[31:0]);
        end
        apb(1, `ADR_SRC_B, 0);
        go();
        chk(DIV_TRAP, 1);
        results();
    end
endmodule
